// >>> common/pcw_pkg.sv
package pcw_pkg;

    // ------------------------------------------------------------
    // warning codes
    // ------------------------------------------------------------
    localparam logic [7:0] WARN_NONE       = 8'h00;
    localparam logic [7:0] WARN_CMD_BAD    = 8'h01;
    localparam logic [7:0] WARN_VALUE_BAD  = 8'h02;
    localparam logic [7:0] WARN_NO_LOAD    = 8'h03;
    localparam logic [7:0] WARN_NO_REF     = 8'h04;
    localparam logic [7:0] WARN_PROD_OFF   = 8'h05;
    localparam logic [7:0] WARN_SER_MOTION = 8'h08;
    localparam logic [7:0] WARN_SECOND_CMD = 8'h0B;
    localparam logic [7:0] WARN_DESC_BAD   = 8'h0F;
    localparam logic [7:0] WARN_LOGIC_MOT  = 8'h12;
    localparam logic [7:0] WARN_CMD_MISS   = 8'h14;
    localparam logic [7:0] WARN_OVERFLOW   = 8'h15;
    localparam logic [7:0] WARN_BAD_CHAR   = 8'h16;
    localparam logic [7:0] WARN_FLUID_OFF  = 8'h18;
    localparam logic [7:0] WARN_PERM_LOW   = 8'h19;
    localparam logic [7:0] WARN_BUSY       = 8'h1A;

    // ------------------------------------------------------------
    // characters, buffer, codes
    // ------------------------------------------------------------
    localparam logic [7:0] CHR_CR     = 8'h0D;
    localparam logic [7:0] CHR_COMMA  = 8'h2C;
    localparam logic [7:0] CHR_SPACE  = 8'h20;
    localparam logic [7:0] CHR_QMARK  = 8'h3F;
    localparam logic [5:0] BUF_DEPTH  = 6'h20;
    localparam logic [7:0] ALERT_MOTOR = 8'h01;
    localparam logic [7:0] ALERT_AIR   = 8'h02;
    localparam logic [7:0] FAULT_AIR   = 8'h01;

    // ------------------------------------------------------------
    // register map (index of a word)
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL      = 4'h0;
    localparam logic [3:0] REG_CMD_RESP  = 4'h1;
    localparam logic [3:0] REG_ALERT     = 4'h2;
    localparam logic [3:0] REG_FAULT     = 4'h3;
    localparam logic [3:0] REG_LD_CFG    = 4'h4;
    localparam logic [3:0] REG_LD_VALUE  = 4'h5;
    localparam logic [3:0] REG_LD_STATUS = 4'h6;
    localparam logic [3:0] REG_AIR_TH    = 4'h7;
    localparam logic [3:0] REG_LIQ_TH    = 4'h8;
    localparam logic [3:0] REG_DET_TIME  = 4'h9;
    localparam logic [3:0] REG_CLEAR     = 4'hA;
    localparam logic [15:0] AIR_TH_RST   = 16'h0100;
    localparam logic [15:0] LIQ_TH_RST   = 16'h0200;
    localparam logic [15:0] DET_TIME_RST = 16'h03E8;

    typedef enum logic [2:0] {
        LD_DISABLED    = 3'b000,
        LD_TUNE_AIR    = 3'b001,
        LD_TUNE_LIQUID = 3'b010,
        LD_STATUS      = 3'b011,
        LD_ALERT_AIR   = 3'b100,
        LD_FAULT_AIR   = 3'b101
    } pcw_ld_cfg_type;

    // command attributes, decoded outside from the command letter
    typedef struct packed {
        logic       known;
        logic       desc_ok;
        logic       value_ok;
        logic       is_start;
        logic       is_prod;
        logic       is_fluid;
        logic       is_motor_set;
        logic       is_clear;
        logic [1:0] perm_need;
    } pcw_cmd_attr_type;

    // response to one command
    typedef struct packed {
        logic [7:0] cmd_char;
        logic [7:0] warn;
    } pcw_resp_type;

endpackage : pcw_pkg

// >>> dv/pcw_cmd_warn_properties.sv
`timescale 1ns/1ps
module pcw_cmd_warn_chk
    import pcw_pkg::*;
(
    input wire logic             i_clk,
    input wire logic             i_rst,
    input wire logic             i_rx_valid,
    input wire logic [7:0]       i_rx_char,
    input wire pcw_cmd_attr_type i_attr,
    input wire logic             i_op_active,
    input wire logic             i_rd,
    input wire logic [31:0]      o_rdata,
    input wire logic             o_resp_valid,
    input wire pcw_resp_type     o_resp,
    input wire logic             o_apply,
    input wire logic             o_start,
    input wire logic             o_pump_stop
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // ------------------------------------------------------------
    // command end and its attributes
    // ------------------------------------------------------------
    sequence s_cr;
        i_rx_valid && i_rx_char == CHR_CR;
    endsequence
    sequence s_cr_unknown;
        s_cr ##0 !i_attr.known;
    endsequence
    sequence s_cr_bad_value;
        s_cr ##0 !i_attr.value_ok;
    endsequence

    a_resp_after_cr: assert property (s_cr |=> o_resp_valid)
        else $error("no response after carriage return");
    a_resp_only_cr: assert property (
        !(i_rx_valid && i_rx_char == CHR_CR) |=> !o_resp_valid)
        else $error("response without carriage return");
    a_resp_holds: assert property (!o_resp_valid |-> $stable(o_resp))
        else $error("response changed between commands");
    a_unknown_no_act: assert property (
        s_cr_unknown |=> !o_apply && !o_start)
        else $error("unknown command acted on");
    a_bad_value_kept: assert property (
        s_cr_bad_value |=> !o_apply && !o_start)
        else $error("out of range value applied");
    a_busy_no_start: assert property (
        s_cr ##0 (i_attr.is_start && i_op_active) |=> !o_start)
        else $error("start accepted while busy");
    a_fault_no_start: assert property (
        s_cr ##0 o_pump_stop |=> !o_start)
        else $error("start accepted during fault");
    a_accept_clean: assert property ((o_start || o_apply) |->
        o_resp_valid && o_resp.warn == WARN_NONE)
        else $error("action taken with a warning");
    a_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0)
        else $error("read data without read strobe");
endmodule : pcw_cmd_warn_chk

bind pcw_cmd_warn pcw_cmd_warn_chk u_chk (.i_clk(i_clk), .i_rst(i_rst),
    .i_rx_valid(i_rx_valid), .i_rx_char(i_rx_char), .i_attr(i_attr),
    .i_op_active(i_op_active), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_resp_valid(o_resp_valid), .o_resp(o_resp), .o_apply(o_apply),
    .o_start(o_start), .o_pump_stop(o_pump_stop));

// >>> dv/pcw_host_model.sv
`timescale 1ns/1ps
module pcw_host_model
    import pcw_pkg::*;
(
    input  wire logic i_clk,
    output logic      o_valid,
    output logic [7:0] o_char
);
    initial begin
        o_valid = 1'b0;
        o_char  = 8'h00;
    end

    // one command: characters, idle gap between them, then return
    task automatic send(input string s, input int gap);
        for (int i = 0; i <= s.len(); i++) begin
            @(posedge i_clk);
            o_valid <= 1'b1;
            o_char  <= (i == s.len()) ? CHR_CR : s[i];
            if (i < s.len()) begin
                repeat (gap) begin
                    @(posedge i_clk);
                    o_valid <= 1'b0;
                    o_char  <= ~o_char;
                end
            end
        end
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_char  <= ~o_char;
    endtask : send
endmodule : pcw_host_model

// >>> dv/tb_pcw_cmd_warn.sv
`timescale 1ns/1ps
module tb_pcw_cmd_warn
    import pcw_pkg::*;
;
    logic i_clk, i_rst, i_rx_valid, i_wr, i_rd, o_resp_valid;
    logic i_loaded, i_referenced, i_op_active, i_port_parked;
    logic i_logic_motion_en, i_motor_sel_changed, o_apply, o_start;
    logic             o_pump_stop;
    logic [7:0]       i_rx_char, o_cmd_char;
    logic [15:0]      i_transmission;
    logic [3:0]       i_addr;
    logic [31:0]      i_wdata, o_rdata;
    pcw_cmd_attr_type i_attr;
    pcw_resp_type     o_resp;
    int               failures, check_count;

    pcw_host_model host (.i_clk(i_clk), .o_valid(i_rx_valid),
        .o_char(i_rx_char));
    pcw_cmd_warn dut (.i_clk(i_clk), .i_rst(i_rst), .i_rx_valid(i_rx_valid),
        .i_rx_char(i_rx_char), .i_attr(i_attr), .i_loaded(i_loaded),
        .i_referenced(i_referenced), .i_op_active(i_op_active),
        .i_port_parked(i_port_parked),
        .i_logic_motion_en(i_logic_motion_en),
        .i_motor_sel_changed(i_motor_sel_changed),
        .i_transmission(i_transmission), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_cmd_char(o_cmd_char), .o_resp_valid(o_resp_valid),
        .o_resp(o_resp), .o_apply(o_apply), .o_start(o_start),
        .o_pump_stop(o_pump_stop));

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    // ------------------------------------------------------------
    // compare, bus and command tasks
    // ------------------------------------------------------------
    task automatic results();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    task automatic chk(input string n, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("wrong value %s expected %0h seen %0h", n, e, s);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk($sformatf("reg %0h", a), o_rdata, e);
    endtask : rd

    task automatic cmd(input string s, input logic [9:0] a,
                       input logic [7:0] w, input logic st,
                       input int gap = 0);
        int n;
        n = 0;
        @(posedge i_clk);
        i_attr <= a;
        host.send(s, gap);
        #1;
        while (o_resp_valid !== 1'b1 && n < 20) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (n == 20) begin
            failures++;
            results();
        end
        chk("warn", o_resp.warn, w);
        chk("start", o_start, st);
        chk("apply", o_apply, w == WARN_NONE && !st);
        if (w == WARN_CMD_MISS) begin
            chk("cmd", o_resp.cmd_char, CHR_QMARK);
        end else begin
            chk("cmd", o_resp.cmd_char, s[0]);
            chk("letter", o_cmd_char, s[0]);
        end
    endtask : cmd

    task automatic wait_cyc(input int c);
        repeat (c) @(posedge i_clk);
    endtask : wait_cyc

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        string s;
        {i_rst, i_wr, i_rd, i_op_active, i_port_parked} = 5'h10;
        {i_loaded, i_referenced, i_logic_motion_en} = 3'h7;
        i_motor_sel_changed = 1'b0;
        i_attr = 10'h000;
        i_addr = 4'h0;
        i_wdata = 32'h0;
        i_transmission = 16'h0150;
        failures = 0;
        check_count = 0;
        wait_cyc(4);
        i_rst <= 1'b0;
        rd(REG_AIR_TH, 32'h100);
        rd(REG_LIQ_TH, 32'h200);
        rd(REG_DET_TIME, 32'h3E8);
        rd(REG_ALERT, 32'h0);
        rd(REG_FAULT, 32'h0);
        rd(4'hF, 32'h0);
        rd(REG_LD_VALUE, 32'h0);
        rd(REG_LD_STATUS, 32'h0);
        cmd("a1", 10'h180, WARN_CMD_BAD, 1'b0, 2);
        cmd("a1", 10'h300, WARN_VALUE_BAD, 1'b0);
        cmd("a1", 10'h280, WARN_DESC_BAD, 1'b0);
        cmd("ab1", 10'h380, WARN_SECOND_CMD, 1'b0);
        cmd("12", 10'h380, WARN_CMD_MISS, 1'b0);
        cmd("a#1", 10'h380, WARN_BAD_CHAR, 1'b0);
        cmd("a1.2,3 -4", 10'h380, WARN_NONE, 1'b0);
        cmd("a1", 10'h381, WARN_PERM_LOW, 1'b0);
        wr(REG_CTRL, 32'h11);
        rd(REG_CTRL, 32'h11);
        cmd("a1", 10'h381, WARN_NONE, 1'b0);
        s = "a";
        repeat (40) s = {s, "1"};
        cmd(s, 10'h380, WARN_OVERFLOW, 1'b0);
        i_op_active <= 1'b1;
        cmd("g1", 10'h3C0, WARN_BUSY, 1'b0);
        {i_op_active, i_port_parked} <= 2'h1;
        cmd("g1", 10'h3C0, WARN_BUSY, 1'b0);
        i_port_parked <= 1'b0;
        cmd("g1", 10'h3E0, WARN_PROD_OFF, 1'b0);
        cmd("g1", 10'h3D0, WARN_FLUID_OFF, 1'b0);
        wr(REG_CTRL, 32'h0);
        cmd("g1", 10'h3C0, WARN_SER_MOTION, 1'b0);
        wr(REG_CTRL, 32'h10);
        i_logic_motion_en <= 1'b0;
        cmd("g1", 10'h3C0, WARN_LOGIC_MOT, 1'b0);
        {i_logic_motion_en, i_referenced} <= 2'h2;
        cmd("g1", 10'h3C0, WARN_NO_REF, 1'b0);
        {i_referenced, i_loaded} <= 2'h2;
        cmd("g1", 10'h3C0, WARN_NO_LOAD, 1'b0);
        i_loaded <= 1'b1;
        cmd("g1", 10'h3C0, WARN_NONE, 1'b1);
        i_transmission <= 16'h0080;
        wr(REG_LD_CFG, 32'h1);
        wait_cyc(3);
        rd(REG_AIR_TH, 32'h80);
        wr(REG_LD_CFG, 32'h2);
        i_transmission <= 16'h0300;
        wait_cyc(3);
        rd(REG_LIQ_TH, 32'h300);
        rd(REG_LD_VALUE, 32'h300);
        rd(REG_AIR_TH, 32'h80);
        wr(REG_DET_TIME, 32'h10);
        wr(REG_LD_CFG, 32'h3);
        wait_cyc(3);
        rd(REG_LD_STATUS, 32'h1);
        i_transmission <= 16'h0100;
        wait_cyc(3);
        rd(REG_LD_STATUS, 32'h1);
        i_transmission <= 16'h0080;
        wait_cyc(40);
        rd(REG_LD_STATUS, 32'h0);
        rd(REG_ALERT, 32'h0);
        rd(REG_FAULT, 32'h0);
        wr(REG_LD_CFG, 32'h6);
        rd(REG_LD_CFG, 32'h3);
        i_transmission <= 16'h0300;
        wr(REG_LD_CFG, 32'h4);
        i_transmission <= 16'h0080;
        wait_cyc(8);
        rd(REG_ALERT, 32'h0);
        wait_cyc(30);
        rd(REG_ALERT, ALERT_AIR);
        chk("stop", o_pump_stop, 1'b0);
        i_transmission <= 16'h0300;
        wait_cyc(3);
        wr(REG_CLEAR, 32'h1);
        rd(REG_ALERT, 32'h0);
        wr(REG_LD_CFG, 32'h5);
        i_transmission <= 16'h0080;
        wait_cyc(40);
        rd(REG_FAULT, FAULT_AIR);
        chk("stop", o_pump_stop, 1'b1);
        // the pump loses its reference with the fault
        i_referenced <= 1'b0;
        cmd("g1", 10'h3C0, WARN_BUSY, 1'b0);
        i_transmission <= 16'h0300;
        wr(REG_LD_CFG, 32'h3);
        cmd("c", 10'h384, WARN_NONE, 1'b0);
        chk("stop", o_pump_stop, 1'b0);
        rd(REG_FAULT, 32'h0);
        cmd("g1", 10'h3C0, WARN_NO_REF, 1'b0);
        i_referenced <= 1'b1;
        @(posedge i_clk);
        i_motor_sel_changed <= 1'b1;
        @(posedge i_clk);
        i_motor_sel_changed <= 1'b0;
        rd(REG_ALERT, ALERT_MOTOR);
        cmd("g1", 10'h3C0, WARN_NONE, 1'b1);
        rd(REG_CMD_RESP, 32'h6700);
        wr(REG_LD_CFG, 32'h0);
        i_transmission <= 16'h0080;
        wait_cyc(3);
        rd(REG_LD_VALUE, 32'h300);
        rd(REG_LD_STATUS, 32'h1);
        results();
    end
endmodule : tb_pcw_cmd_warn

// >>> logic/pcw_cmd_warn.sv
`timescale 1ns/1ps
// Overview of operation
// - unknown command answers warning 1
// - out-of-range value answers warning 2
// - start needs load (3) and reference (4)
// - production disabled refuses with warning 5
// - motion off: serial 8, logic input 18
// - second letter before CR: discard, warning 11
// - bad descriptor answers warning 15
// - no letter: warning 20, question mark
// - command longer than buffer: warning 21
// - illegal character gives warning 22
// - fluidic disabled refuses with warning 24
// - permission too low gives warning 25
// - busy or parked start gives warning 26
// - alert and fault codes read zero clear
// - motor selection change raises alert
// - fault blocks operation until clear faults
// - disabled detector inactive, status frozen
// - tuning modes copy value into threshold
// - status mode never alerts nor faults
// - air over detection time raises alert
// - air over detection time raises fault
// - two thresholds, liquid above air
module pcw_cmd_warn
    import pcw_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_rx_valid,
    input  wire logic [7:0]       i_rx_char,
    input  wire pcw_cmd_attr_type i_attr,
    input  wire logic             i_loaded,
    input  wire logic             i_referenced,
    input  wire logic             i_op_active,
    input  wire logic             i_port_parked,
    input  wire logic             i_logic_motion_en,
    input  wire logic             i_motor_sel_changed,
    input  wire logic [15:0]      i_transmission,
    input  wire logic [3:0]       i_addr,
    input  wire logic [31:0]      i_wdata,
    input  wire logic             i_wr,
    input  wire logic             i_rd,
    output logic [31:0]           o_rdata,
    output logic [7:0]            o_cmd_char,
    output logic                  o_resp_valid,
    output pcw_resp_type          o_resp,
    output logic                  o_apply,
    output logic                  o_start,
    output logic                  o_pump_stop
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] meta_q;
    logic [1:0] sync_q;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= 2'b00;
            sync_q <= 2'b00;
        end else begin
            meta_q <= {i_logic_motion_en, i_port_parked};
            sync_q <= meta_q;
        end
    end

    // logic reads only the second stage of each synchroniser
    wire logic logic_mot_en = sync_q[1];
    wire logic parked       = sync_q[0];

    // ------------------------------------------------------------
    // character parser
    // ------------------------------------------------------------
    logic [7:0] letter_q;
    logic       have_letter_q;
    logic       second_q;
    logic       bad_char_q;
    logic       overflow_q;
    logic [5:0] count_q;

    wire logic is_alpha = (i_rx_char >= 8'h41 && i_rx_char <= 8'h5A)
                       || (i_rx_char >= 8'h61 && i_rx_char <= 8'h7A);
    wire logic is_digit = i_rx_char >= 8'h30 && i_rx_char <= 8'h39;
    wire logic is_delim = i_rx_char == CHR_COMMA
                       || i_rx_char == CHR_SPACE
                       || i_rx_char == 8'h2E
                       || i_rx_char == 8'h2D;
    wire logic is_cr    = i_rx_valid && i_rx_char == CHR_CR;
    wire logic take     = i_rx_valid && !is_cr;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            letter_q      <= 8'h00;
            have_letter_q <= 1'b0;
            second_q      <= 1'b0;
            bad_char_q    <= 1'b0;
            overflow_q    <= 1'b0;
            count_q       <= 6'h00;
        end else if (is_cr) begin
            have_letter_q <= 1'b0;
            second_q      <= 1'b0;
            bad_char_q    <= 1'b0;
            overflow_q    <= 1'b0;
            count_q       <= 6'h00;
        end else if (take) begin
            if (count_q == BUF_DEPTH)
                overflow_q <= 1'b1;
            else
                count_q <= count_q + 6'h01;
            if (is_alpha && have_letter_q)
                second_q <= 1'b1;
            if (is_alpha && !have_letter_q) begin
                letter_q      <= i_rx_char;
                have_letter_q <= 1'b1;
            end
            if (!is_alpha && !is_digit && !is_delim)
                bad_char_q <= 1'b1;
        end
    end

    assign o_cmd_char = letter_q;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [1:0]     perm_q;
    logic           prod_en_q;
    logic           fluid_en_q;
    logic           ser_mot_en_q;
    pcw_ld_cfg_type ld_cfg_q;
    logic [15:0]    air_th_q;
    logic [15:0]    liq_th_q;
    logic [15:0]    det_time_q;
    logic [7:0]     alert_q;
    logic [7:0]     fault_q;
    logic           ld_liquid_q;
    logic [15:0]    air_cnt_q;
    logic [15:0]    trans_q;

    wire logic wr_ctrl  = i_wr && i_addr == REG_CTRL;
    wire logic wr_cfg   = i_wr && i_addr == REG_LD_CFG;
    wire logic wr_air   = i_wr && i_addr == REG_AIR_TH;
    wire logic wr_liq   = i_wr && i_addr == REG_LIQ_TH;
    wire logic wr_time  = i_wr && i_addr == REG_DET_TIME;
    wire logic wr_clear = i_wr && i_addr == REG_CLEAR;
    // a reserved configuration code leaves the old one in place
    wire logic cfg_legal = i_wdata[2:0] <= 3'h5;

    // ------------------------------------------------------------
    // command check at carriage return
    // ------------------------------------------------------------
    logic [7:0] warn;

    always_comb begin
        warn = WARN_NONE;
        if (overflow_q)
            warn = WARN_OVERFLOW;
        else if (second_q)
            warn = WARN_SECOND_CMD;
        else if (bad_char_q)
            warn = WARN_BAD_CHAR;
        else if (!have_letter_q)
            warn = WARN_CMD_MISS;
        else if (!i_attr.known)
            warn = WARN_CMD_BAD;
        else if (!i_attr.desc_ok)
            warn = WARN_DESC_BAD;
        else if (i_attr.perm_need > perm_q)
            warn = WARN_PERM_LOW;
        else if (!i_attr.value_ok)
            warn = WARN_VALUE_BAD;
        else if (i_attr.is_start) begin
            if (i_op_active || parked)
                warn = WARN_BUSY;
            else if (fault_q != 8'h00)
                warn = WARN_BUSY;
            else if (i_attr.is_prod && !prod_en_q)
                warn = WARN_PROD_OFF;
            else if (i_attr.is_fluid && !fluid_en_q)
                warn = WARN_FLUID_OFF;
            else if (!ser_mot_en_q)
                warn = WARN_SER_MOTION;
            else if (!logic_mot_en)
                warn = WARN_LOGIC_MOT;
            else if (!i_referenced)
                warn = WARN_NO_REF;
            else if (!i_loaded)
                warn = WARN_NO_LOAD;
        end
    end

    wire logic ok       = is_cr && warn == WARN_NONE;
    wire logic clr_cmd  = (ok && i_attr.is_clear) || wr_clear;
    wire logic [7:0] resp_cmd = have_letter_q ? letter_q : CHR_QMARK;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_resp_valid <= 1'b0;
            o_resp       <= '0;
            o_apply      <= 1'b0;
            o_start      <= 1'b0;
        end else begin
            o_resp_valid <= is_cr;
            o_apply      <= ok && !i_attr.is_start;
            o_start      <= ok && i_attr.is_start;
            if (is_cr)
                o_resp <= '{cmd_char: resp_cmd, warn: warn};
        end
    end

    // ------------------------------------------------------------
    // line detector
    // ------------------------------------------------------------
    wire logic ld_on  = ld_cfg_q != LD_DISABLED;
    wire logic ld_det = ld_cfg_q == LD_STATUS
                     || ld_cfg_q == LD_ALERT_AIR
                     || ld_cfg_q == LD_FAULT_AIR;
    wire logic go_liq = trans_q >= liq_th_q;
    wire logic go_air = trans_q <= air_th_q;
    wire logic air_long = !ld_liquid_q && air_cnt_q > det_time_q;

    // ------------------------------------------------------------
    // detector events
    // ------------------------------------------------------------
    // status-only mode classifies but never raises an event
    wire logic air_event = air_long
                        && (ld_cfg_q == LD_ALERT_AIR
                            || ld_cfg_q == LD_FAULT_AIR);
    wire logic air_alert_set = air_event && ld_cfg_q == LD_ALERT_AIR;
    wire logic air_fault_set = air_event && ld_cfg_q == LD_FAULT_AIR;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            trans_q     <= 16'h0000;
            ld_liquid_q <= 1'b0;
            air_cnt_q   <= 16'h0000;
        end else begin
            if (ld_on)
                trans_q <= i_transmission;
            if (ld_det && go_liq)
                ld_liquid_q <= 1'b1;
            else if (ld_det && go_air)
                ld_liquid_q <= 1'b0;
            if (!ld_det || ld_liquid_q)
                air_cnt_q <= 16'h0000;
            else if (air_cnt_q != 16'hFFFF)
                air_cnt_q <= air_cnt_q + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // settings, alert and fault codes
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            perm_q       <= 2'b00;
            prod_en_q    <= 1'b0;
            fluid_en_q   <= 1'b0;
            ser_mot_en_q <= 1'b1;
            ld_cfg_q     <= LD_DISABLED;
            air_th_q     <= AIR_TH_RST;
            liq_th_q     <= LIQ_TH_RST;
            det_time_q   <= DET_TIME_RST;
            alert_q      <= 8'h00;
            fault_q      <= 8'h00;
        end else begin
            if (wr_ctrl) begin
                perm_q       <= i_wdata[1:0];
                prod_en_q    <= i_wdata[2];
                fluid_en_q   <= i_wdata[3];
                ser_mot_en_q <= i_wdata[4];
            end
            if (wr_cfg && cfg_legal)
                ld_cfg_q <= pcw_ld_cfg_type'(i_wdata[2:0]);
            if (ld_cfg_q == LD_TUNE_AIR)
                air_th_q <= trans_q;
            else if (wr_air)
                air_th_q <= i_wdata[15:0];
            if (ld_cfg_q == LD_TUNE_LIQUID)
                liq_th_q <= trans_q;
            else if (wr_liq)
                liq_th_q <= i_wdata[15:0];
            if (wr_time)
                det_time_q <= i_wdata[15:0];
            // set wins over clear
            if (i_motor_sel_changed)
                alert_q <= ALERT_MOTOR;
            else if (air_alert_set)
                alert_q <= ALERT_AIR;
            else if (wr_clear)
                alert_q <= 8'h00;
            if (air_fault_set)
                fault_q <= FAULT_AIR;
            else if (clr_cmd)
                fault_q <= 8'h00;
        end
    end

    assign o_pump_stop = fault_q != 8'h00;

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (i_addr == REG_CTRL)
            rd_mux = {27'h0, ser_mot_en_q, fluid_en_q, prod_en_q, perm_q};
        else if (i_addr == REG_CMD_RESP)
            rd_mux = {16'h0, o_resp};
        else if (i_addr == REG_ALERT)
            rd_mux = {24'h0, alert_q};
        else if (i_addr == REG_FAULT)
            rd_mux = {24'h0, fault_q};
        else if (i_addr == REG_LD_CFG)
            rd_mux = {29'h0, ld_cfg_q};
        else if (i_addr == REG_LD_VALUE)
            rd_mux = {16'h0, trans_q};
        else if (i_addr == REG_LD_STATUS)
            rd_mux = {31'h0, ld_liquid_q};
        else if (i_addr == REG_AIR_TH)
            rd_mux = {16'h0, air_th_q};
        else if (i_addr == REG_LIQ_TH)
            rd_mux = {16'h0, liq_th_q};
        else if (i_addr == REG_DET_TIME)
            rd_mux = {16'h0, det_time_q};
    end

    // read data stand for each cycle after a cycle with i_rd high, and read zero otherwise
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst)
            o_rdata <= 32'h0000_0000;
        else if (i_rd)
            o_rdata <= rd_mux;
        else
            o_rdata <= 32'h0000_0000;
    end

endmodule : pcw_cmd_warn
